// >>> inc/udc_pkg.sv
package udc_pkg;
  localparam int LINES = 24;
  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 32;
  localparam int RD_W = 32;
  localparam int BANK_B_LO = 8;
  localparam int BANK_CL_LO = 16;
  localparam int BANK_CH_LO = 20;
  localparam int BANK_A = 0;
  localparam int BANK_B = 1;
  localparam int BANK_CL = 2;
  localparam int BANK_CH = 3;
  localparam logic [3:0] DIR_RESET = 4'hf;
  localparam logic [23:0] OUT_RESET = 24'h000000;
  localparam logic [31:0] CNT_RESET = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;
  localparam logic [31:0] CNT_MAX = 32'hffffffff;
  localparam logic RD_LINES = 1'b0;
  localparam logic RD_COUNT = 1'b1;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLINK_HALF_MS = 100;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLASH_BLINKS = 3;
  localparam logic [2:0] FLASH_TOGGLES = 3'(2 * FLASH_BLINKS);
  localparam int CNT_MAX_FREQ_MHZ = 1;
  typedef enum logic [1:0] {
    UDC_LED_OFF = 2'b00,
    UDC_LED_ON = 2'b01,
    UDC_LED_FLASH = 2'b10,
    UDC_LED_BLINK = 2'b11
  } udc_led_state_t;
endpackage

// >>> inc/udc_led_if.sv
`timescale 1ns/1ps
interface udc_led_if;
  logic attached;
  logic comm_ok;
  logic xfer;
  logic blink_tick;
  logic led;
  modport src (output attached, output comm_ok, output xfer, output blink_tick, input led);
  modport ind (input attached, input comm_ok, input xfer, input blink_tick, output led);
endinterface

// >>> logic/udc_led.sv
`timescale 1ns/1ps
module udc_led (
  input wire logic ref_clk,
  input wire logic arst_n,
  udc_led_if.ind lif
);
  udc_pkg::udc_led_state_t state;
  udc_pkg::udc_led_state_t next_state;
  logic [2:0] flash_left;
  logic [2:0] next_flash_left;
  logic comm_q;
  logic lost;
  logic next_led;
  wire comm_fall = comm_q & ~lif.comm_ok;
  wire link_ok = lif.attached & lif.comm_ok & ~lost;
  wire toggle = lif.blink_tick ? ~lif.led : lif.led;

  // ----------------------------------------
  // Indicator sequencing
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_flash_left = flash_left;
    next_led = lif.led;
    if (!link_ok)
    begin
      next_state = udc_pkg::UDC_LED_OFF;
      next_led = 1'b0;
    end
    else
    begin
      case (state)
        udc_pkg::UDC_LED_OFF:
        begin
          next_state = udc_pkg::UDC_LED_FLASH;
          next_flash_left = udc_pkg::FLASH_TOGGLES;
          next_led = 1'b0;
        end
        udc_pkg::UDC_LED_FLASH:
        begin
          next_led = toggle;
          if (lif.blink_tick)
          begin
            if (flash_left == 3'h0)
            begin
              next_state = udc_pkg::UDC_LED_ON;
              next_led = 1'b1;
            end
            else
            begin
              next_flash_left = flash_left - 3'h1;
            end
          end
        end
        udc_pkg::UDC_LED_ON:
        begin
          next_led = 1'b1;
          if (lif.xfer)
          begin
            next_state = udc_pkg::UDC_LED_BLINK;
          end
        end
        udc_pkg::UDC_LED_BLINK:
        begin
          next_led = toggle;
          if (!lif.xfer)
          begin
            next_state = udc_pkg::UDC_LED_ON;
            next_led = 1'b1;
          end
        end
        default:
        begin
          next_state = udc_pkg::UDC_LED_OFF;
          next_led = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= udc_pkg::UDC_LED_OFF;
      flash_left <= 3'h0;
      lif.led <= 1'b0;
      comm_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      flash_left <= next_flash_left;
      lif.led <= next_led;
      comm_q <= lif.comm_ok;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lost <= 1'b0;
    end
    else if (!lif.attached)
    begin
      lost <= 1'b0;
    end
    else if (comm_fall)
    begin
      lost <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  led_lost_off_a: assert property (!lif.comm_ok |=> !lif.led)
    else $error("indicator lit without communication");
  led_relight_a: assert property (lost && lif.attached |=> !lif.led)
    else $error("indicator relit before reattach");
  led_steady_a: assert property (
    state == udc_pkg::UDC_LED_ON && link_ok && !lif.xfer |=> lif.led && $stable(state))
    else $error("indicator not steady while idle");
  led_blink_a: assert property (
    state == udc_pkg::UDC_LED_BLINK && link_ok && lif.xfer && lif.blink_tick
    |=> lif.led != $past(lif.led))
    else $error("indicator not toggling during transfer");
  flash_end_a: assert property (
    state == udc_pkg::UDC_LED_FLASH && flash_left == 3'h0 && lif.blink_tick && link_ok
    |=> state == udc_pkg::UDC_LED_ON && lif.led)
    else $error("flash sequence did not end steady on");
  flash_start_a: assert property (
    state == udc_pkg::UDC_LED_OFF && link_ok
    |=> state == udc_pkg::UDC_LED_FLASH && flash_left == udc_pkg::FLASH_TOGGLES && !lif.led)
    else $error("flash sequence did not start with six toggles");
endmodule

// >>> logic/udc_top.sv
// Contract
// - Indicator steady on when connected and idle
// - Indicator blinks continuously during data transfer
// - First communication: three blinks, then steady
// - No control can disable the indicator
// - Off on loss, relit after reattach
// - 24 lines, per-port direction selectable
// - Input lines read pin level
// - One 32-bit event counter on dedicated pin
// - Count rising edges only, ignore falling
// - Every rising edge counted up to 1 MHz
// - Reset leaves all lines as inputs
// - Banks grouped 8+8+4+4 or 8+8+8
`timescale 1ns/1ps
module udc_top #(
  parameter int BLINK_HALF_CYC = udc_pkg::BLINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic host_attached,
  input wire logic host_comm_ok,
  input wire logic host_xfer,
  input wire logic dir_wr,
  input wire logic dir_grp_three,
  input wire logic [3:0] dir_in,
  input wire logic out_wr,
  input wire logic [23:0] out_data,
  input wire logic rd_req,
  input wire logic rd_sel,
  input wire logic event_count_input,
  input wire logic [23:0] digital_line_in,
  output logic [23:0] digital_line_out,
  output logic [23:0] digital_line_oe,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic [31:0] count_value,
  output logic grp_three,
  output logic status_led
);
  // ----------------------------------------
  // Direction and output latches
  // ----------------------------------------
  logic [3:0] dir_q;
  logic [23:0] next_oe;
  logic [23:0] line_value;
  logic cnt_prev;
  logic [31:0] tick_cnt;
  logic blink_tick;
  wire [3:0] eff_dir;
  wire cnt_rise;
  wire [31:0] next_count;
  wire [31:0] next_rd_data;
  wire tick_wrap;

  assign eff_dir[udc_pkg::BANK_A] = dir_q[udc_pkg::BANK_A];
  assign eff_dir[udc_pkg::BANK_B] = dir_q[udc_pkg::BANK_B];
  assign eff_dir[udc_pkg::BANK_CL] = dir_q[udc_pkg::BANK_CL];
  assign eff_dir[udc_pkg::BANK_CH] = grp_three ? dir_q[udc_pkg::BANK_CL] : dir_q[udc_pkg::BANK_CH];

  genvar gi;
  generate
    for (gi = 0; gi < udc_pkg::LINES; gi = gi + 1)
    begin : g_line
      localparam int BANK = (gi < udc_pkg::BANK_B_LO) ? udc_pkg::BANK_A :
                            (gi < udc_pkg::BANK_CL_LO) ? udc_pkg::BANK_B :
                            (gi < udc_pkg::BANK_CH_LO) ? udc_pkg::BANK_CL : udc_pkg::BANK_CH;
      assign next_oe[gi] = ~eff_dir[BANK];
      assign line_value[gi] = eff_dir[BANK] ? digital_line_in[gi] : digital_line_out[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir_q <= udc_pkg::DIR_RESET;
      grp_three <= 1'b0;
      digital_line_oe <= '0;
    end
    else
    begin
      if (dir_wr)
      begin
        dir_q <= dir_in;
        grp_three <= dir_grp_three;
      end
      digital_line_oe <= next_oe;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      digital_line_out <= udc_pkg::OUT_RESET;
    end
    else if (out_wr)
    begin
      digital_line_out <= out_data;
    end
  end

  // ----------------------------------------
  // Event counter
  // ----------------------------------------
  // rising edge detect
  assign cnt_rise = event_count_input & ~cnt_prev;
  assign next_count = count_value + udc_pkg::CNT_ONE;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_prev <= 1'b0;
      count_value <= udc_pkg::CNT_RESET;
    end
    else
    begin
      cnt_prev <= event_count_input;
      if (cnt_rise)
      begin
        count_value <= next_count;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  assign next_rd_data = (rd_sel == udc_pkg::RD_COUNT) ? count_value : {8'h00, line_value};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      rd_valid <= rd_req;
      if (rd_req)
      begin
        rd_data <= next_rd_data;
      end
    end
  end

  // ----------------------------------------
  // Blink divider
  // ----------------------------------------
  assign tick_wrap = (tick_cnt == 32'(BLINK_HALF_CYC - 1));

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt <= '0;
      blink_tick <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 32'h00000001;
      blink_tick <= tick_wrap;
    end
  end

  // ----------------------------------------
  // Status indicator
  // ----------------------------------------
  udc_led_if lif ();

  assign lif.attached = host_attached;
  assign lif.comm_ok = host_comm_ok;
  assign lif.xfer = host_xfer;
  assign lif.blink_tick = blink_tick;

  udc_led u_led (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .lif(lif)
  );

  assign status_led = lif.led;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  cnt_rise_a: assert property (cnt_rise |=> count_value == $past(next_count))
    else $error("counter missed a rising edge");
  cnt_fall_a: assert property (!cnt_rise |=> $stable(count_value))
    else $error("counter moved without a rising edge");
  cnt_pulse_a: assert property (
    !event_count_input ##1 event_count_input
    |=> count_value == $past(count_value, 1) + 32'h00000001)
    else $error("counter did not count a legal pulse");
  cnt_wrap_a: assert property (
    cnt_rise && count_value == udc_pkg::CNT_MAX |=> count_value == udc_pkg::CNT_RESET)
    else $error("counter did not wrap to zero");
  oe_reset_a: assert property ($rose(arst_n) |-> digital_line_oe == 24'h000000)
    else $error("lines driven after reset");
  oe_bank_a: assert property (
    dir_wr |=> ##1 digital_line_oe[7:0] == {8{~$past(dir_in[0], 2)}})
    else $error("bank direction not applied");
  grp_three_a: assert property (
    dir_wr && dir_grp_three |=> ##1 digital_line_oe[23:20] == digital_line_oe[19:16])
    else $error("upper nibble not following in three-bank mode");
  rd_line_a: assert property (
    rd_req && rd_sel == udc_pkg::RD_LINES
    |=> rd_valid && rd_data[23:0] == $past(line_value))
    else $error("line read mismatch");
  rd_count_a: assert property (
    rd_req && rd_sel == udc_pkg::RD_COUNT |=> rd_valid && rd_data == $past(count_value))
    else $error("counter read mismatch");
endmodule

// >>> verification/udc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host and terminal-side sources
// ----------------------------------------
module udc_host_model (
  input wire logic ref_clk,
  output logic host_attached,
  output logic host_comm_ok,
  output logic host_xfer,
  output logic event_count_input,
  output logic [23:0] pin_ext
);
  initial
  begin
    host_attached = 1'b0;
    host_comm_ok = 1'b0;
    host_xfer = 1'b0;
    event_count_input = 1'b0;
    pin_ext = 24'h000000;
  end

  task automatic link(input logic a, input logic c, input logic x);
    @(negedge ref_clk);
    host_attached = a;
    host_comm_ok = c;
    host_xfer = x;
  endtask

  task automatic pins(input logic [23:0] v);
    @(negedge ref_clk);
    pin_ext = v;
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      event_count_input = 1'b1;
      repeat (2) @(negedge ref_clk);
      event_count_input = 1'b0;
      @(negedge ref_clk);
    end
  endtask
endmodule

// >>> verification/udc_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the digital I/O core
// ----------------------------------------
module udc_top_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic host_attached, host_comm_ok, host_xfer, event_count_input;
  logic dir_wr = 1'b0;
  logic dir_grp_three = 1'b0;
  logic out_wr = 1'b0;
  logic rd_req = 1'b0;
  logic rd_sel = 1'b0;
  logic [3:0] dir_in = 4'h0;
  logic [23:0] out_data = 24'h000000;
  logic [23:0] pin_ext, digital_line_in, digital_line_out, digital_line_oe;
  logic [31:0] rd_data, count_value;
  logic [31:0] exp_cnt = 32'h00000000;
  logic rd_valid, grp_three, status_led;
  int failures = 0;
  int num_checks = 0;
  int f, o;

  always #4 ref_clk = ~ref_clk;
  assign digital_line_in = (digital_line_oe & digital_line_out) | (~digital_line_oe & pin_ext);

  udc_host_model u_host (.ref_clk(ref_clk), .host_attached(host_attached),
    .host_comm_ok(host_comm_ok), .host_xfer(host_xfer),
    .event_count_input(event_count_input), .pin_ext(pin_ext));

  udc_top #(.BLINK_HALF_CYC(4)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .host_attached(host_attached), .host_comm_ok(host_comm_ok), .host_xfer(host_xfer),
    .dir_wr(dir_wr), .dir_grp_three(dir_grp_three), .dir_in(dir_in), .out_wr(out_wr),
    .out_data(out_data), .rd_req(rd_req), .rd_sel(rd_sel),
    .event_count_input(event_count_input), .digital_line_in(digital_line_in),
    .digital_line_out(digital_line_out), .digital_line_oe(digital_line_oe),
    .rd_data(rd_data), .rd_valid(rd_valid), .count_value(count_value),
    .grp_three(grp_three), .status_led(status_led));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic watch(input int n, output int falls, output int ons);
    logic prev;
    prev = status_led;
    falls = 0;
    ons = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (prev === 1'b1 && status_led === 1'b0)
        falls++;
      if (status_led === 1'b1)
        ons++;
      prev = status_led;
    end
  endtask

  task automatic dir_chk(input logic grp, input logic [3:0] din, input logic [23:0] exp);
    @(negedge ref_clk);
    dir_wr = 1'b1;
    dir_grp_three = grp;
    dir_in = din;
    @(negedge ref_clk);
    dir_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(32'(digital_line_oe), 32'(exp));
    check(32'(grp_three), 32'(grp));
  endtask

  task automatic rd_chk(input logic sel, input logic [31:0] exp);
    @(negedge ref_clk);
    rd_req = 1'b1;
    rd_sel = sel;
    @(negedge ref_clk);
    rd_req = 1'b0;
    check(32'(rd_valid), 32'h1);
    check(rd_data, exp);
    @(negedge ref_clk);
    check(32'(rd_valid), 32'h0);
  endtask

  task automatic led_flash;
    u_host.link(1'b1, 1'b1, 1'b0);
    watch(60, f, o);
    check(32'(f), 32'h3);
    watch(20, f, o);
    check(32'(o), 32'd20);
  endtask

  task automatic io_chk;
    u_host.pins(24'h3c96f0);
    dir_chk(1'b0, 4'b1010, 24'h0f00ff);
    @(negedge ref_clk);
    out_wr = 1'b1;
    out_data = 24'ha5c35a;
    @(negedge ref_clk);
    out_wr = 1'b0;
    @(negedge ref_clk);
    check(32'(digital_line_out), 32'h00a5c35a);
    rd_chk(1'b0, 32'h0035965a);
    u_host.pins(24'hc3690f);
    rd_chk(1'b0, 32'h00c5695a);
    dir_chk(1'b1, 4'b0110, 24'h0000ff);
  endtask

  task automatic cnt_chk;
    u_host.pulses(5);
    exp_cnt = exp_cnt + 32'd5;
    repeat (2) @(negedge ref_clk);
    check(count_value, exp_cnt);
    rd_chk(1'b1, exp_cnt);
  endtask

  task automatic led_loss;
    u_host.link(1'b1, 1'b0, 1'b0);
    watch(2, f, o);
    watch(20, f, o);
    check(32'(o), 32'h0);
    u_host.link(1'b1, 1'b1, 1'b0);
    watch(30, f, o);
    check(32'(o), 32'h0);
    u_host.link(1'b0, 1'b0, 1'b0);
    watch(4, f, o);
    led_flash();
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    check(32'(digital_line_oe), 32'h0);
    check(count_value, 32'h0);
    check(32'(status_led), 32'h0);
    led_flash();
    u_host.link(1'b1, 1'b1, 1'b1);
    watch(40, f, o);
    check(32'(f >= 3), 32'h1);
    u_host.link(1'b1, 1'b1, 1'b0);
    watch(4, f, o);
    io_chk();
    cnt_chk();
    watch(20, f, o);
    check(32'(o), 32'd20);
    led_loss();
    end_sim();
  end
endmodule
